// ---- tb/tb_ptpcc_top.sv ----
`timescale 1ns/1ps
module tb_ptpcc_top;
   import ptpcc_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   typedef struct {string name; logic [31:0] d; logic err; bit care;} ptpcc_note_s;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, raw;
   logic stamp_pin_a, stamp_pin_b;
   ptpcc_tx_evt_s [2:0] tx_evt;
   ptpcc_note_s notes[$];
   int n_fail, n_checks, cyc;
   logic [11:0] rst_offs [13] = '{OFF_P1_UUID, OFF_P2_UUID, OFF_P0_UUID, OFF_PA_HI, OFF_PA_LO,
      OFF_PB_HI, OFF_PB_LO, OFF_CLK_HI, OFF_CLK_LO, OFF_ADDEND, OFF_TGT_HI, OFF_TGT_LO, OFF_STATUS};
   logic [11:0] id_offs [3] = '{OFF_P0_UUID, OFF_P1_UUID, OFF_P2_UUID};

   ptpcc_top i_ptpcc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .stamp_pin_a(stamp_pin_a), .stamp_pin_b(stamp_pin_b), .tx_evt(tx_evt),
      .irq(irq));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // ---------------------------------------------------------------
   // Reporting
   // ---------------------------------------------------------------
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic close_out();
      if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out

   // Hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         close_out();
      end
   end

   // Read results are matched against the oldest note
   always @(posedge pclk) begin
      ptpcc_note_s n;
      if (presetn && psel && penable && pready && !pwrite) begin
         if (notes.size() == 0) check("unexpected read", 32'h0, 32'h1);
         else begin
            n = notes.pop_front();
            if (n.care) check(n.name, prdata, n.d);
            check({n.name, " error"}, {31'h0, pslverr}, {31'h0, n.err});
         end
      end
   end

   // ---------------------------------------------------------------
   // APB master
   // ---------------------------------------------------------------
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] q);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge keeps a following request from re-assigning psel in this step
      @(posedge pclk);
   endtask : apb

   task automatic wr(logic [11:0] a, logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask : wr

   task automatic rd(string name, logic [11:0] a, logic [31:0] e, bit care = 1, logic err = 0);
      notes.push_back('{name, e, err, care});
      apb(1'b0, a, 32'h0, raw);
   endtask : rd

   task automatic rd64(string name, logic [11:0] a, logic [63:0] e);
      rd(name, a, e[63:32]);
      rd(name, a + 12'h004, e[31:0]);
   endtask : rd64

   task automatic ld_clk(logic [63:0] v);
      wr(OFF_CLK_HI, v[63:32]);
      wr(OFF_CLK_LO, v[31:0]);
   endtask : ld_clk

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      logic [63:0] c1, c2, s1;
      logic [31:0] a, b, lo;
      logic [31:0] ids [3];
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      stamp_pin_a = 1'b0;
      stamp_pin_b = 1'b0;
      tx_evt = '0;
      ids = '{32'h0, 32'h0, 32'h0};
      void'($urandom(32'hF0EE));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rst_offs[i]) rd("reset value", rst_offs[i], RST_WORD);
      wr(OFF_PA_HI, $urandom);
      wr(OFF_P1_UUID, $urandom);
      rd("ro capture", OFF_PA_HI, RST_WORD);
      rd("ro uuid", OFF_P1_UUID, RST_WORD);
      // Addend kept below 2^28 so its few cycles of summing cannot carry: the clock
      // must still read zero in the half-write check below
      a = $urandom >> 4;
      wr(OFF_ADDEND, a);
      rd("addend", OFF_ADDEND, a);
      wr(OFF_ADDEND, 32'h0);
      rd("unmapped", 12'h004, 32'h0, 1, 1'b1);
      // Half-written clock must not land; reads show the frozen copy only
      c1 = {$urandom, $urandom};
      wr(OFF_CLK_HI, c1[63:32]);
      wr(OFF_CMD, 32'h1);
      rd64("clk half", OFF_CLK_HI, RST_TIME);
      wr(OFF_CLK_LO, c1[31:0]);
      rd("clk live", OFF_CLK_HI, RST_WORD);
      wr(OFF_CMD, 32'h1);
      rd64("clk load", OFF_CLK_HI, c1);
      // Half-rate addend: exactly one step per two cycles between freezes 100 apart
      wr(OFF_ADDEND, 32'h8000_0000);
      wr(OFF_CMD, 32'h1);
      rd("rate start hi", OFF_CLK_HI, 32'h0, 0);
      s1[63:32] = raw;
      rd("rate start lo", OFF_CLK_LO, 32'h0, 0);
      s1[31:0] = raw;
      repeat (91) @(posedge pclk);
      wr(OFF_CMD, 32'h1);
      rd("rate end lo", OFF_CLK_LO, 32'h0, 0);
      lo = raw;
      check("rate", lo - s1[31:0], 32'd50);
      wr(OFF_ADDEND, 32'h0);
      // Pins: a held level must not recapture, a fresh edge overwrites
      for (int p = 0; p < 2; p++) begin
         c1 = {$urandom, $urandom};
         c2 = {$urandom, $urandom};
         ld_clk(c1);
         if (p == 0) stamp_pin_a <= 1'b1;
         else stamp_pin_b <= 1'b1;
         repeat (2) @(posedge pclk);
         ld_clk(c2);
         rd64("pin held", p ? OFF_PB_HI : OFF_PA_HI, c1);
         if (p == 0) stamp_pin_a <= 1'b0;
         else stamp_pin_b <= 1'b0;
         @(posedge pclk);
         if (p == 0) stamp_pin_a <= 1'b1;
         else stamp_pin_b <= 1'b1;
         @(posedge pclk);
         if (p == 0) stamp_pin_a <= 1'b0;
         else stamp_pin_b <= 1'b0;
         @(posedge pclk);
         rd64("pin capture", p ? OFF_PB_HI : OFF_PA_HI, c2);
      end
      rd("pin status", OFF_STATUS, 32'h6);
      wr(OFF_CLEAR, 32'h3F);
      // Compare: target half write stays inactive; full write matches the stopped clock
      wr(OFF_TGT_HI, c2[63:32]);
      rd("target half", OFF_TGT_HI, RST_WORD);
      rd("no match", OFF_STATUS, 32'h0);
      wr(OFF_TGT_LO, c2[31:0]);
      rd("match", OFF_STATUS, 32'h1);
      check("irq masked", {31'h0, irq}, 32'h0);
      wr(OFF_ENABLE, 32'h1);
      check("irq on", {31'h0, irq}, 32'h1);
      wr(OFF_CLEAR, 32'h1);
      check("irq cleared", {31'h0, irq}, 32'h0);
      rd("match once", OFF_STATUS, 32'h0);
      // Clock reloaded onto the target with the match enabled raises the line
      ld_clk(~c2);
      ld_clk(c2);
      @(posedge pclk);
      check("irq match", {31'h0, irq}, 32'h1);
      rd("match again", OFF_STATUS, 32'h1);
      wr(OFF_CLEAR, 32'h1);
      // Transmit: role picks the message type, each port keeps its own word
      wr(OFF_ENABLE, 32'h38);
      for (int r = 0; r < 2; r++) begin
         wr(OFF_ROLE, r ? 32'h7 : 32'h0);
         for (int p = 0; p < 3; p++) begin
            a = $urandom;
            b = $urandom;
            tx_evt[p] <= {1'b1, 1'b0, a};
            @(posedge pclk);
            tx_evt[p] <= {1'b0, 1'b1, b};
            @(posedge pclk);
            tx_evt[p] <= '0;
            @(posedge pclk);
            ids[p] = r ? a : b;
            for (int q = 0; q < 3; q++) rd("origin id", id_offs[q], ids[q]);
         end
      end
      rd("role", OFF_ROLE, 32'h7);
      rd("enable", OFF_ENABLE, 32'h38);
      rd("tx status", OFF_STATUS, 32'h38);
      check("irq tx", {31'h0, irq}, 32'h1);
      wr(OFF_CLEAR, 32'h38);
      check("irq tx clear", {31'h0, irq}, 32'h0);
      // Mid-run reset must clear captures and the running state
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rst_offs[i]) rd("reset again", rst_offs[i], RST_WORD);
      close_out();
   end
endmodule : tb_ptpcc_top

// ---- verilog/ptpcc_pkg.sv ----
package ptpcc_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [11:0] OFF_P1_UUID = 12'h11C;
   localparam logic [11:0] OFF_P2_UUID = 12'h13C;
   localparam logic [11:0] OFF_P0_UUID = 12'h15C;
   localparam logic [11:0] OFF_PA_HI = 12'h160;
   localparam logic [11:0] OFF_PA_LO = 12'h164;
   localparam logic [11:0] OFF_PB_HI = 12'h168;
   localparam logic [11:0] OFF_PB_LO = 12'h16C;
   localparam logic [11:0] OFF_CLK_HI = 12'h170;
   localparam logic [11:0] OFF_CLK_LO = 12'h174;
   localparam logic [11:0] OFF_ADDEND = 12'h178;
   localparam logic [11:0] OFF_TGT_HI = 12'h17C;
   localparam logic [11:0] OFF_TGT_LO = 12'h180;
   localparam logic [11:0] OFF_CMD = 12'h1A0;
   localparam logic [11:0] OFF_ROLE = 12'h1A4;
   localparam logic [11:0] OFF_STATUS = 12'h1A8;
   localparam logic [11:0] OFF_CLEAR = 12'h1AC;
   localparam logic [11:0] OFF_ENABLE = 12'h1B0;

   // ---------------------------------------------------------------
   // Field positions and sizes
   // ---------------------------------------------------------------
   localparam int N_PORTS = 3;
   localparam int N_EVT = 6;
   localparam int EVT_CMP = 0;
   localparam int EVT_PIN_A = 1;
   localparam int EVT_PIN_B = 2;
   localparam int EVT_TX0 = 3;
   localparam int CMD_FREEZE_BIT = 0;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [63:0] RST_TIME = 64'h0000_0000_0000_0000;
   localparam logic EQ_PREV_RST = 1'b1;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic sync_sent;
      logic delay_req_sent;
      logic [31:0] sent_origin_id_lower;
   } ptpcc_tx_evt_s;

   typedef struct packed {
      logic [63:0] clock;
      logic [31:0] acc;
      logic [31:0] addend;
      logic [63:0] snap;
      logic [63:0] clk_stage;
      logic clk_hi_w;
      logic clk_lo_w;
      logic [63:0] target;
      logic [63:0] tgt_stage;
      logic tgt_hi_w;
      logic tgt_lo_w;
      logic [63:0] cap_a;
      logic [63:0] cap_b;
      logic [N_PORTS-1:0][31:0] uuid;
      logic [N_PORTS-1:0] role;
      logic [N_EVT-1:0] status;
      logic [N_EVT-1:0] enable;
      logic [1:0] pin_prev;
      logic eq_prev;
      logic [31:0] rdata;
   } ptpcc_state_s;

endpackage : ptpcc_pkg

// ---- verilog/ptpcc_top.sv ----
`timescale 1ns/1ps
// What this block does
// - One 64-bit time clock, split in two halves, feeds both pin captures and the frozen copy.
// - Clock runs from the 100 MHz base, rate trimmed by the addend.
// - Addend summed into a 32-bit accumulator each cycle; carries step the clock.
// - Clock write lands only once both halves are written.
// - Clock reads return the copy frozen by the freeze command bit.
// - 64-bit target compared with the clock; a match can raise the interrupt.
// - New target lands only once both target halves are written.
// - Pin A activation latches the clock into its capture pair 160h/164h.
// - Pin B activation latches the clock into its capture pair 168h/16Ch.
// - Qualifying transmit stores the low origin id per port; resets to zero.
// - Separate origin id capture per port at 11Ch, 13Ch and 15Ch.
// - Each port's master bit selects Sync or Delay_Req capture on transmit.
// - Master captures on sent Sync; slave captures on sent Delay_Req.
// - Port 0 transmit means traffic heading toward the switch fabric.
module ptpcc_top (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   // Timestamp pins
   input wire logic stamp_pin_a,
   input wire logic stamp_pin_b,
   // Transmit events, index is the port number
   input wire ptpcc_pkg::ptpcc_tx_evt_s [2:0] tx_evt,
   // Interrupt
   output logic irq
);
   import ptpcc_pkg::*;

   ptpcc_state_s st_reg;
   ptpcc_state_s st_next;

   logic acc_carry;
   logic [31:0] acc_sum;
   logic wr_en;
   logic rd_setup;
   logic clk_ld;
   logic [63:0] clk_ld_val;
   logic tgt_ld;
   logic [63:0] tgt_ld_val;
   logic pin_a_rise;
   logic pin_b_rise;
   logic cmp_eq;
   logic cmp_rise;
   logic [N_PORTS-1:0] tx_hit;
   logic [N_EVT-1:0] evt;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   function automatic logic is_mapped(input logic [11:0] a);
      case (a)
         OFF_P1_UUID, OFF_P2_UUID, OFF_P0_UUID,
         OFF_PA_HI, OFF_PA_LO, OFF_PB_HI, OFF_PB_LO,
         OFF_CLK_HI, OFF_CLK_LO, OFF_ADDEND, OFF_TGT_HI, OFF_TGT_LO,
         OFF_CMD, OFF_ROLE, OFF_STATUS, OFF_CLEAR, OFF_ENABLE: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction : is_mapped

   function automatic logic [31:0] read_word(input logic [11:0] a, input ptpcc_state_s s);
      case (a)
         OFF_P0_UUID: read_word = s.uuid[0];
         OFF_P1_UUID: read_word = s.uuid[1];
         OFF_P2_UUID: read_word = s.uuid[2];
         OFF_PA_HI: read_word = s.cap_a[63:32];
         OFF_PA_LO: read_word = s.cap_a[31:0];
         OFF_PB_HI: read_word = s.cap_b[63:32];
         OFF_PB_LO: read_word = s.cap_b[31:0];
         OFF_CLK_HI: read_word = s.snap[63:32];
         OFF_CLK_LO: read_word = s.snap[31:0];
         OFF_ADDEND: read_word = s.addend;
         OFF_TGT_HI: read_word = s.target[63:32];
         OFF_TGT_LO: read_word = s.target[31:0];
         OFF_ROLE: read_word = {29'h0000_0000, s.role};
         OFF_STATUS: read_word = {26'h000_0000, s.status};
         OFF_ENABLE: read_word = {26'h000_0000, s.enable};
         default: read_word = RST_WORD;
      endcase
   endfunction : read_word

   // ---------------------------------------------------------------
   // APB handshake
   // ---------------------------------------------------------------
   // Read data is fetched in the setup cycle so prdata comes from a flop
   // with no wait state; the price is that a live value is one cycle old.
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~is_mapped(paddr);
   assign prdata = st_reg.rdata;
   assign wr_en = psel & penable & pwrite & is_mapped(paddr);
   assign rd_setup = psel & ~penable & ~pwrite;

   // ---------------------------------------------------------------
   // Rate accumulator
   // ---------------------------------------------------------------
   assign {acc_carry, acc_sum} = {1'b0, st_reg.acc} + {1'b0, st_reg.addend};

   // ---------------------------------------------------------------
   // Paired half writes
   // ---------------------------------------------------------------
   // A write completes the pair when the other half is already staged.
   assign clk_ld = wr_en & (((paddr == OFF_CLK_HI) & st_reg.clk_lo_w) |
                            ((paddr == OFF_CLK_LO) & st_reg.clk_hi_w));
   assign clk_ld_val = (paddr == OFF_CLK_HI) ? {pwdata, st_reg.clk_stage[31:0]}
                                             : {st_reg.clk_stage[63:32], pwdata};
   assign tgt_ld = wr_en & (((paddr == OFF_TGT_HI) & st_reg.tgt_lo_w) |
                            ((paddr == OFF_TGT_LO) & st_reg.tgt_hi_w));
   assign tgt_ld_val = (paddr == OFF_TGT_HI) ? {pwdata, st_reg.tgt_stage[31:0]}
                                             : {st_reg.tgt_stage[63:32], pwdata};

   // ---------------------------------------------------------------
   // Events
   // ---------------------------------------------------------------
   assign pin_a_rise = stamp_pin_a & ~st_reg.pin_prev[0];
   assign pin_b_rise = stamp_pin_b & ~st_reg.pin_prev[1];
   assign cmp_eq = (st_reg.clock == st_reg.target);
   // Only the first cycle of equality counts, so a stopped clock sitting
   // on the target raises one event rather than a stream of them.
   assign cmp_rise = cmp_eq & ~st_reg.eq_prev;

   // Port 0 sees transmit as traffic toward the fabric; its sent flags
   // come from that direction.
   genvar gp;
   generate
      for (gp = 0; gp < N_PORTS; gp++) begin : g_port
         assign tx_hit[gp] = st_reg.role[gp] ? tx_evt[gp].sync_sent
                                             : tx_evt[gp].delay_req_sent;
      end
   endgenerate

   always_comb begin
      evt = '0;
      evt[EVT_CMP] = cmp_rise;
      evt[EVT_PIN_A] = pin_a_rise;
      evt[EVT_PIN_B] = pin_b_rise;
      evt[EVT_TX0 +: N_PORTS] = tx_hit;
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.acc = acc_sum;
      if (acc_carry) begin
         st_next.clock = st_reg.clock + 64'h0000_0000_0000_0001;
      end
      // Clock halves
      if (wr_en && paddr == OFF_CLK_HI) begin
         st_next.clk_stage[63:32] = pwdata;
         st_next.clk_hi_w = 1'b1;
      end
      if (wr_en && paddr == OFF_CLK_LO) begin
         st_next.clk_stage[31:0] = pwdata;
         st_next.clk_lo_w = 1'b1;
      end
      if (clk_ld) begin
         st_next.clock = clk_ld_val;
         st_next.clk_hi_w = 1'b0;
         st_next.clk_lo_w = 1'b0;
      end
      // Target halves
      if (wr_en && paddr == OFF_TGT_HI) begin
         st_next.tgt_stage[63:32] = pwdata;
         st_next.tgt_hi_w = 1'b1;
      end
      if (wr_en && paddr == OFF_TGT_LO) begin
         st_next.tgt_stage[31:0] = pwdata;
         st_next.tgt_lo_w = 1'b1;
      end
      if (tgt_ld) begin
         st_next.target = tgt_ld_val;
         st_next.tgt_hi_w = 1'b0;
         st_next.tgt_lo_w = 1'b0;
      end
      // Plain control registers
      if (wr_en && paddr == OFF_ADDEND) begin
         st_next.addend = pwdata;
      end
      if (wr_en && paddr == OFF_CMD && pwdata[CMD_FREEZE_BIT]) begin
         st_next.snap = st_reg.clock;
      end
      if (wr_en && paddr == OFF_ROLE) begin
         st_next.role = pwdata[N_PORTS-1:0];
      end
      if (wr_en && paddr == OFF_ENABLE) begin
         st_next.enable = pwdata[N_EVT-1:0];
      end
      // Captures; software writes to these offsets are ignored
      st_next.pin_prev = {stamp_pin_b, stamp_pin_a};
      if (pin_a_rise) begin
         st_next.cap_a = st_reg.clock;
      end
      if (pin_b_rise) begin
         st_next.cap_b = st_reg.clock;
      end
      for (int p = 0; p < N_PORTS; p++) begin
         if (tx_hit[p]) begin
            st_next.uuid[p] = tx_evt[p].sent_origin_id_lower;
         end
      end
      st_next.eq_prev = cmp_eq;
      // Set wins over a clear landing in the same cycle
      if (wr_en && paddr == OFF_CLEAR) begin
         st_next.status = st_reg.status & ~pwdata[N_EVT-1:0];
      end
      st_next.status = st_next.status | evt;
      if (rd_setup) begin
         st_next.rdata = read_word(paddr, st_reg);
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
         st_reg.eq_prev <= EQ_PREV_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign irq = |(st_reg.status & st_reg.enable);

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_clock_step: assert property (
      (acc_carry && !clk_ld) |=> st_reg.clock == $past(st_reg.clock) + 64'h1)
      else $error("clock did not step on accumulator carry");

   chk_clock_idle: assert property (
      (!acc_carry && !clk_ld) |=> $stable(st_reg.clock))
      else $error("clock moved without a carry");

   chk_clock_pair: assert property (
      clk_ld |=> st_reg.clock == $past(clk_ld_val) && !st_reg.clk_hi_w && !st_reg.clk_lo_w)
      else $error("paired clock write not applied");

   chk_clock_half: assert property (
      (wr_en && paddr == OFF_CLK_HI && !st_reg.clk_lo_w)
      |=> st_reg.clk_hi_w ##1 (st_reg.clock - $past(st_reg.clock, 2)) <= 64'h2)
      else $error("single half write disturbed the clock");

   chk_freeze_copy: assert property (
      (wr_en && paddr == OFF_CMD && pwdata[CMD_FREEZE_BIT])
      |=> st_reg.snap == $past(st_reg.clock))
      else $error("freeze did not copy the clock");

   chk_snap_read: assert property (
      (rd_setup && paddr == OFF_CLK_LO) |=> prdata == $past(st_reg.snap[31:0]))
      else $error("clock read not from frozen copy");

   chk_target_pair: assert property (
      tgt_ld |=> st_reg.target == $past(tgt_ld_val))
      else $error("paired target write not applied");

   chk_target_half: assert property (
      (wr_en && paddr == OFF_TGT_LO && !st_reg.tgt_hi_w) |=> $stable(st_reg.target))
      else $error("single half write changed the target");

   chk_match_irq: assert property (
      (cmp_rise && st_reg.enable[EVT_CMP]) |=> st_reg.status[EVT_CMP] && irq)
      else $error("compare match did not raise interrupt");

   chk_pin_a_cap: assert property (
      (stamp_pin_a && !st_reg.pin_prev[0]) |=> st_reg.cap_a == $past(st_reg.clock))
      else $error("pin A capture wrong");

   chk_pin_b_cap: assert property (
      (stamp_pin_b && !st_reg.pin_prev[1]) |=> st_reg.cap_b == $past(st_reg.clock))
      else $error("pin B capture wrong");

   chk_pin_once: assert property (
      (stamp_pin_a && $past(stamp_pin_a)) |=> $stable(st_reg.cap_a))
      else $error("pin A captured twice for one event");

   chk_tx_uuid: assert property (
      (st_reg.role[1] && tx_evt[1].sync_sent)
      |=> st_reg.uuid[1] == $past(tx_evt[1].sent_origin_id_lower))
      else $error("master port 1 missed sent sync");

   chk_slave_skip: assert property (
      (!st_reg.role[2] && !tx_evt[2].delay_req_sent) |=> $stable(st_reg.uuid[2]))
      else $error("slave port 2 captured on wrong message");

   chk_pin_b_once: assert property (
      (stamp_pin_b && $past(stamp_pin_b)) |=> $stable(st_reg.cap_b))
      else $error("pin B captured twice for one event");

   // Software writes to the pin A high and port 1 origin id offsets must leave the captured words alone
   chk_capture_ro: assert property (
      (wr_en && paddr == OFF_PA_HI && !pin_a_rise) |=> $stable(st_reg.cap_a))
      else $error("pin A capture changed by a write");

   chk_uuid_ro: assert property (
      (wr_en && paddr == OFF_P1_UUID && !tx_hit[1]) |=> $stable(st_reg.uuid[1]))
      else $error("port 1 origin id changed by a write");

   chk_addend_write: assert property (
      (wr_en && paddr == OFF_ADDEND) |=> st_reg.addend == $past(pwdata))
      else $error("addend write not applied");

   // Port 0 as slave: a delay request sent toward the fabric is captured
   chk_tx_slave: assert property (
      (!st_reg.role[0] && tx_evt[0].delay_req_sent)
      |=> st_reg.uuid[0] == $past(tx_evt[0].sent_origin_id_lower))
      else $error("slave port 0 missed sent delay request");

   // A load consumes both staged halves, so the next pair starts afresh
   chk_target_clear: assert property (
      tgt_ld |=> !st_reg.tgt_hi_w && !st_reg.tgt_lo_w)
      else $error("target staging not cleared after load");

   // At half rate a carry is always followed by a cycle without one
   chk_half_rate: assert property (
      (st_reg.addend == 32'h8000_0000 && acc_carry && !(wr_en && paddr == OFF_ADDEND))
      |=> !acc_carry)
      else $error("half-rate addend carried twice in a row");

   // Status bits hold until software clears them
   chk_status_sticky: assert property (
      (st_reg.status[EVT_PIN_A] && !(wr_en && paddr == OFF_CLEAR)) |=> st_reg.status[EVT_PIN_A])
      else $error("pin A status dropped without a clear");

endmodule : ptpcc_top
